// ---- design/user_io_map.svh ----
`ifndef USER_IO_MAP_SVH
`define USER_IO_MAP_SVH

`define NUM_OUTPUTS       4
`define NUM_INPUTS        8
`define HOME_INPUT_IDX    6
`define TAMPER_INPUT_IDX  7
`define ANALOG_W          8
`define MV_PER_COUNT      20
`define MV_MAX            5000
`define HOME_FLAG_NUM     9
`define TAMPER_FLAG_NUM   32
`define LATCH_FLAG_NUM    40
`define RESET_OUT_BYTE    4'h0
`define RESET_LATCHES     8'h00

`endif

// ---- design/user_io_pkg.sv ----
package user_io_pkg;

    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_OUT_ON,
        CMD_OUT_OFF,
        CMD_QUERY_OUT_BYTE,
        CMD_QUERY_OUT_ONE,
        CMD_QUERY_IN_BYTE,
        CMD_QUERY_LATCH,
        CMD_QUERY_LIVE,
        CMD_QUERY_ANALOG,
        CMD_CLEAR_LATCH_FLAG,
        CMD_TEST_INPUT,
        CMD_TEST_BELOW,
        CMD_TEST_ABOVE,
        CMD_SET_HOME_FLAG,
        CMD_SET_TAMPER_FLAG,
        CMD_SAVE
    } cmd_op_t;

    typedef struct packed {
        logic         valid;
        cmd_op_t      op;
        logic [3:0]   index;
        logic [12:0]  mv;
        logic         value;
        logic         run;
        logic         foreground;
        logic         in_script;
    } cmd_t;

    typedef struct packed {
        logic         valid;
        logic         refused;
        logic [15:0]  value;
    } reply_t;

    typedef struct packed {
        logic         valid;
        logic         take;
    } jump_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_RUN
    } run_state_t;

    typedef struct packed {
        logic [2:0]   in_meta;
        logic [2:0]   in_sync;
        logic [4:0]   in_prev;
        logic [1:0]   aux_meta;
        logic [1:0]   aux_sync;
        logic [7:0]   latches;
        logic [3:0]   outputs;
        logic [3:0]   pend_on;
        logic [3:0]   pend_off;
        run_state_t   state;
        logic         home_as_input;
        logic         tamper_as_input;
        logic         saved_home;
        logic         saved_tamper;
        reply_t       reply;
        jump_t        jump;
        logic         any_latch_flag;
        logic         home_enable;
        logic         tamper_enable;
        logic         timestamp_enable;
    } state_t;

endpackage

// ---- design/user_io_latch_and_query.sv ----
// Functional notes
// - Output-on command turns selected user output 1 to 4 on.
// - Output-off command turns selected user output 1 to 4 off.
// - Output commands wait for run; foreground modifier executes them at once.
// - Single output query replies 1 when output on, 0 when off.
// - Output byte query replies one bit per output, bit set when on.
// - Each input has a latch set by falling edge, held until cleared; code sets only inputs 1 to 3, and 7 and 8 when remapped.
// - Any-latch flag is 1 whenever any input latch is set.
// - Explicitly clearing the any-latch flag clears every input latch.
// - Input commands use latched edge state unless stated otherwise.
// - Input byte query returns all latch bits and leaves them unchanged.
// - Single latch query on inputs 1 to 8 replies then clears latch.
// - Live queries on inputs 1 to 3 reply 1 when low, latch untouched.
// - Analog inputs 1 and 2 reported as counts of twenty millivolts.
// - Queries execute on arrival without run and are refused in scripts.
// - Script input test jumps when chosen input 1 to 8 is true.
// - Analog tests compare input 1 against 0 to 5000 mV, jump if holds.
// - Home flag set makes home button input 7 and disables homing.
// - Tamper flag set makes tamper pin input 8, enables timestamping.
// - Home and tamper settings survive reset only when saved.
`include "user_io_map.svh"

module user_io_latch_and_query #(
    parameter int NUM_OUTPUTS = `NUM_OUTPUTS,
    parameter int ANALOG_W    = `ANALOG_W
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire user_io_pkg::cmd_t    cmd,
    input  wire logic [2:0]           user_in_n,
    input  wire logic                 home_button_n,
    input  wire logic                 tamper_pin_n,
    input  wire logic [ANALOG_W-1:0]  analog1_count,
    input  wire logic [ANALOG_W-1:0]  analog2_count,
    output logic [NUM_OUTPUTS-1:0]    user_out,
    output user_io_pkg::reply_t       reply,
    output user_io_pkg::jump_t        jump,
    output logic                      any_latch_flag,
    output logic                      home_enable,
    output logic                      tamper_enable,
    output logic                      timestamp_enable
);

    // Power-on value gives the saved settings a known start, since rst keeps them
    user_io_pkg::state_t s_r = '0;
    user_io_pkg::state_t s_nxt;

    // One-hot select from a 1-based index; out of range gives zero
    function automatic logic [7:0] sel_onehot(input logic [3:0] idx);
        logic [7:0] m;
        m = 8'h00;
        if (idx >= 4'h1 && idx <= 4'h8) begin
            m = 8'h01 << (idx - 4'h1);
        end
        return m;
    endfunction

    // Counts of 20 mV converted to millivolts for comparison
    function automatic logic [15:0] count_to_mv(input logic [ANALOG_W-1:0] c);
        logic [15:0] wide;
        wide = 16'(c);
        return 16'(wide * 16'(`MV_PER_COUNT));
    endfunction

    logic [7:0]  live_true;
    logic [7:0]  falling;
    logic [7:0]  clear_mask;
    logic [7:0]  sel;
    logic [3:0]  osel;
    logic [15:0] a1_mv;
    logic        query_op;
    logic        out_op;

    always_comb begin
        s_nxt      = s_r;
        sel        = sel_onehot(cmd.index);
        osel       = sel[3:0];
        a1_mv      = count_to_mv(analog1_count);
        clear_mask = 8'h00;

        // Second flop only feeds logic; first stage is read by nothing else
        s_nxt.in_meta  = user_in_n;
        s_nxt.in_sync  = s_r.in_meta;
        s_nxt.aux_meta = {home_button_n, tamper_pin_n};
        s_nxt.aux_sync = s_r.aux_meta;
        s_nxt.in_prev  = {s_r.aux_sync, s_r.in_sync};

        // Inputs are active low; home/tamper join only when remapped
        live_true = 8'h00;
        live_true[2:0] = ~s_r.in_sync;
        live_true[`HOME_INPUT_IDX]   = s_r.home_as_input & ~s_r.aux_sync[1];
        live_true[`TAMPER_INPUT_IDX] = s_r.tamper_as_input & ~s_r.aux_sync[0];
        falling = 8'h00;
        falling[2:0] = s_r.in_prev[2:0] & ~s_r.in_sync;
        falling[`HOME_INPUT_IDX] = s_r.home_as_input & s_r.in_prev[4]
                                   & ~s_r.aux_sync[1];
        falling[`TAMPER_INPUT_IDX] = s_r.tamper_as_input & s_r.in_prev[3]
                                     & ~s_r.aux_sync[0];

        query_op = cmd.op inside {user_io_pkg::CMD_QUERY_OUT_BYTE,
                                  user_io_pkg::CMD_QUERY_OUT_ONE,
                                  user_io_pkg::CMD_QUERY_IN_BYTE,
                                  user_io_pkg::CMD_QUERY_LATCH,
                                  user_io_pkg::CMD_QUERY_LIVE,
                                  user_io_pkg::CMD_QUERY_ANALOG};
        out_op = cmd.op inside {user_io_pkg::CMD_OUT_ON, user_io_pkg::CMD_OUT_OFF};

        s_nxt.reply = '0;
        s_nxt.jump  = '0;

        if (cmd.valid) begin
            if (query_op && cmd.in_script) begin
                s_nxt.reply.valid   = 1'b1;
                s_nxt.reply.refused = 1'b1;
            end else begin
                case (cmd.op)
                    user_io_pkg::CMD_OUT_ON: begin
                        s_nxt.pend_on  = s_r.pend_on | osel;
                        s_nxt.pend_off = s_r.pend_off & ~osel;
                    end
                    user_io_pkg::CMD_OUT_OFF: begin
                        s_nxt.pend_off = s_r.pend_off | osel;
                        s_nxt.pend_on  = s_r.pend_on & ~osel;
                    end
                    user_io_pkg::CMD_QUERY_OUT_BYTE: begin
                        s_nxt.reply.valid = 1'b1;
                        s_nxt.reply.value = 16'(s_r.outputs);
                    end
                    user_io_pkg::CMD_QUERY_OUT_ONE: begin
                        s_nxt.reply.valid = 1'b1;
                        s_nxt.reply.refused = (osel == 4'h0);
                        s_nxt.reply.value = 16'(|(s_r.outputs & osel));
                    end
                    user_io_pkg::CMD_QUERY_IN_BYTE: begin
                        s_nxt.reply.valid = 1'b1;
                        s_nxt.reply.value = 16'(s_r.latches);
                    end
                    user_io_pkg::CMD_QUERY_LATCH: begin
                        s_nxt.reply.valid = 1'b1;
                        s_nxt.reply.refused = (sel == 8'h00);
                        s_nxt.reply.value = 16'(|(s_r.latches & sel));
                        clear_mask = sel;
                    end
                    user_io_pkg::CMD_QUERY_LIVE: begin
                        // Only inputs 1 to 3 have a live query
                        s_nxt.reply.valid = 1'b1;
                        s_nxt.reply.refused = (sel[7:3] != 5'h00) || (sel == 8'h00);
                        s_nxt.reply.value = 16'(|(live_true[2:0] & sel[2:0]));
                    end
                    user_io_pkg::CMD_QUERY_ANALOG: begin
                        s_nxt.reply.valid = 1'b1;
                        s_nxt.reply.value = (cmd.index == 4'h2) ? 16'(analog2_count)
                                                                : 16'(analog1_count);
                    end
                    user_io_pkg::CMD_CLEAR_LATCH_FLAG: begin
                        clear_mask = 8'hff;
                    end
                    user_io_pkg::CMD_TEST_INPUT: begin
                        // Latched edge state decides, not the live pin
                        s_nxt.jump.valid = 1'b1;
                        s_nxt.jump.take  = |(s_r.latches & sel);
                    end
                    user_io_pkg::CMD_TEST_BELOW: begin
                        s_nxt.jump.valid = cmd.mv <= 13'(`MV_MAX);
                        s_nxt.jump.take  = (cmd.mv <= 13'(`MV_MAX))
                                           && (a1_mv < 16'(cmd.mv));
                    end
                    user_io_pkg::CMD_TEST_ABOVE: begin
                        s_nxt.jump.valid = cmd.mv <= 13'(`MV_MAX);
                        s_nxt.jump.take  = (cmd.mv <= 13'(`MV_MAX))
                                           && (a1_mv > 16'(cmd.mv));
                    end
                    user_io_pkg::CMD_SET_HOME_FLAG: begin
                        s_nxt.home_as_input = cmd.value;
                    end
                    user_io_pkg::CMD_SET_TAMPER_FLAG: begin
                        s_nxt.tamper_as_input = cmd.value;
                    end
                    user_io_pkg::CMD_SAVE: begin
                        s_nxt.saved_home   = s_r.home_as_input;
                        s_nxt.saved_tamper = s_r.tamper_as_input;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Pending output changes apply on run, or at once under foreground
        case (s_r.state)
            user_io_pkg::ST_IDLE: begin
                if (cmd.valid && out_op && !cmd.foreground && !cmd.run) begin
                    s_nxt.state = user_io_pkg::ST_WAIT_RUN;
                end
            end
            user_io_pkg::ST_WAIT_RUN: begin
                if (cmd.valid && cmd.run) begin
                    s_nxt.state = user_io_pkg::ST_IDLE;
                end
            end
            default: s_nxt.state = user_io_pkg::ST_IDLE;
        endcase
        if (cmd.valid && (cmd.run || (out_op && cmd.foreground))) begin
            s_nxt.outputs  = (s_nxt.outputs | s_nxt.pend_on) & ~s_nxt.pend_off;
            s_nxt.pend_on  = 4'h0;
            s_nxt.pend_off = 4'h0;
        end

        // Edge set wins over any clear in the same cycle
        s_nxt.latches = (s_r.latches & ~clear_mask) | falling;
        s_nxt.any_latch_flag = |s_nxt.latches;

        s_nxt.home_enable      = ~s_nxt.home_as_input;
        s_nxt.tamper_enable    = ~s_nxt.tamper_as_input;
        s_nxt.timestamp_enable = s_nxt.tamper_as_input;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.in_meta          <= 3'h7;
            s_r.in_sync          <= 3'h7;
            s_r.in_prev          <= 5'h1f;
            s_r.aux_meta         <= 2'h3;
            s_r.aux_sync         <= 2'h3;
            s_r.latches          <= `RESET_LATCHES;
            s_r.outputs          <= `RESET_OUT_BYTE;
            s_r.pend_on          <= 4'h0;
            s_r.pend_off         <= 4'h0;
            s_r.state            <= user_io_pkg::ST_IDLE;
            // Saved settings are retained across reset; unsaved ones revert
            s_r.home_as_input    <= s_r.saved_home;
            s_r.tamper_as_input  <= s_r.saved_tamper;
            s_r.saved_home       <= s_r.saved_home;
            s_r.saved_tamper     <= s_r.saved_tamper;
            s_r.reply            <= '0;
            s_r.jump             <= '0;
            s_r.any_latch_flag   <= 1'b0;
            s_r.home_enable      <= ~s_r.saved_home;
            s_r.tamper_enable    <= ~s_r.saved_tamper;
            s_r.timestamp_enable <= s_r.saved_tamper;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign user_out         = s_r.outputs;
    assign reply            = s_r.reply;
    assign jump             = s_r.jump;
    assign any_latch_flag   = s_r.any_latch_flag;
    assign home_enable      = s_r.home_enable;
    assign tamper_enable    = s_r.tamper_enable;
    assign timestamp_enable = s_r.timestamp_enable;

endmodule // user_io_latch_and_query

// ---- bench/user_io_checker.sv ----
module user_io_checker #(
    parameter int NUM_OUTPUTS = 4,
    parameter int ANALOG_W    = 8
) (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire user_io_pkg::cmd_t      cmd,
    input wire logic [2:0]             user_in_n,
    input wire logic                   home_button_n,
    input wire logic                   tamper_pin_n,
    input wire logic [ANALOG_W-1:0]    analog1_count,
    input wire logic [ANALOG_W-1:0]    analog2_count,
    input wire logic [NUM_OUTPUTS-1:0] user_out,
    input wire user_io_pkg::reply_t    reply,
    input wire user_io_pkg::jump_t     jump,
    input wire logic                   any_latch_flag,
    input wire logic                   home_enable,
    input wire logic                   tamper_enable,
    input wire logic                   timestamp_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    reply_has_cause_a: assert property (reply.valid |-> $past(cmd.valid))
        else $error("reply without a command");
    query_refused_a: assert property (cmd.valid && cmd.in_script && cmd.op inside
        {[user_io_pkg::CMD_QUERY_OUT_BYTE:user_io_pkg::CMD_QUERY_ANALOG]}
        |=> reply.valid && reply.refused) else $error("script query not refused");
    fg_on_a: assert property (cmd.valid && cmd.op == user_io_pkg::CMD_OUT_ON && cmd.foreground
        && cmd.index inside {[1:4]} |=> user_out[$past(cmd.index) - 4'h1]) else $error("not on");
    fg_off_a: assert property (cmd.valid && cmd.op == user_io_pkg::CMD_OUT_OFF && cmd.foreground
        && cmd.index inside {[1:4]} |=> !user_out[$past(cmd.index) - 4'h1]) else $error("not off");
    hold_pending_a: assert property (cmd.valid && !cmd.run && !cmd.foreground && cmd.op inside
        {user_io_pkg::CMD_OUT_ON, user_io_pkg::CMD_OUT_OFF} |=> $stable(user_out))
        else $error("output moved without run");
    out_byte_a: assert property (cmd.valid && !cmd.in_script && cmd.op ==
        user_io_pkg::CMD_QUERY_OUT_BYTE |=> reply.value == 16'($past(user_out)))
        else $error("output byte wrong");
    in_byte_flag_a: assert property (cmd.valid && !cmd.in_script && cmd.op ==
        user_io_pkg::CMD_QUERY_IN_BYTE |=> (reply.value != 16'h0) == $past(any_latch_flag))
        else $error("latch flag disagrees with input byte");
    home_mode_a: assert property (cmd.valid && cmd.op == user_io_pkg::CMD_SET_HOME_FLAG
        |=> home_enable == !$past(cmd.value)) else $error("home enable wrong");
    tamper_mode_a: assert property (cmd.valid && cmd.op == user_io_pkg::CMD_SET_TAMPER_FLAG
        |=> tamper_enable == !$past(cmd.value) && timestamp_enable == $past(cmd.value))
        else $error("tamper mode wrong");
    analog_below_a: assert property (cmd.valid && cmd.in_script && cmd.mv <= 13'd5000
        && cmd.op == user_io_pkg::CMD_TEST_BELOW |=> jump.valid && jump.take ==
        (int'($past(analog1_count)) * 20 < int'($past(cmd.mv)))) else $error("below test wrong");
    cover property (reply.valid && reply.refused);
    cover property (jump.valid && jump.take);
    cover property ($fell(any_latch_flag));
endmodule // user_io_checker

bind user_io_latch_and_query user_io_checker #(.NUM_OUTPUTS(NUM_OUTPUTS), .ANALOG_W(ANALOG_W))
    chk (.clk(clk), .rst(rst), .cmd(cmd), .user_in_n(user_in_n), .home_button_n(home_button_n),
    .tamper_pin_n(tamper_pin_n), .analog1_count(analog1_count), .analog2_count(analog2_count),
    .user_out(user_out), .reply(reply), .jump(jump), .any_latch_flag(any_latch_flag),
    .home_enable(home_enable), .tamper_enable(tamper_enable),
    .timestamp_enable(timestamp_enable));

// ---- bench/host_model.sv ----
module host_model (
    input wire logic            clk,
    input wire user_io_pkg::reply_t reply,
    input wire user_io_pkg::jump_t  jump,
    output user_io_pkg::cmd_t   cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cmd = '0;
    // Mode m is {value, run, foreground, in_script}
    task automatic send(input user_io_pkg::cmd_op_t op, input logic [3:0] i,
                        input logic [12:0] mv, input logic [3:0] m,
                        output user_io_pkg::reply_t r, output user_io_pkg::jump_t j);
        user_io_pkg::cmd_t c;
        @(negedge clk);
        cmd <= '{1'b1, op, i, mv, m[3], m[2], m[1], m[0]};
        @(negedge clk);
        // Idle fields are scrambled so nothing leans on stale values
        c = ~cmd;
        c.valid = 1'b0;
        cmd <= c;
        r = reply;
        j = jump;
    endtask
endmodule // host_model

// ---- bench/user_io_latch_and_query_test.sv ----
module user_io_latch_and_query_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic [2:0]          in_n = 3'h7;
    logic                home_n = 1'b1;
    logic                tamp_n = 1'b1;
    logic [7:0]          a1 = 8'h7c;
    logic [7:0]          a2 = 8'h19;
    user_io_pkg::cmd_t   cmd;
    user_io_pkg::reply_t rp, r;
    user_io_pkg::jump_t  jp, j;
    logic [3:0]          uo;
    logic                flag, he, te, tse;
    int                  fails = 0;
    int                  n_compared = 0;
    int                  cyc = 0;
    initial forever #5 clk = ~clk;
    user_io_latch_and_query dut (.clk(clk), .rst(rst), .cmd(cmd), .user_in_n(in_n),
        .home_button_n(home_n), .tamper_pin_n(tamp_n), .analog1_count(a1), .analog2_count(a2),
        .user_out(uo), .reply(rp), .jump(jp), .any_latch_flag(flag), .home_enable(he),
        .tamper_enable(te), .timestamp_enable(tse));
    host_model host (.clk(clk), .reply(rp), .jump(jp), .cmd(cmd));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end
    task automatic tx(input user_io_pkg::cmd_op_t op, input logic [3:0] i, input logic [3:0] m);
        host.send(op, i, 13'h0, m, r, j);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        // Synchroniser needs three cycles before pin edges count
        repeat (3) @(negedge clk);
    endtask
    task automatic t_outputs;
        for (int i = 1; i <= 4; i++) begin
            tx(user_io_pkg::CMD_OUT_ON, 4'(i), 4'h2);
            check("out_on", 16'((1 << i) - 1), 16'(uo));
        end
        tx(user_io_pkg::CMD_OUT_OFF, 4'h2, 4'h2);
        check("out_off", 16'hd, 16'(uo));
        tx(user_io_pkg::CMD_QUERY_OUT_BYTE, 4'h0, 4'h0);
        check("out_byte", 16'hd, r.value);
        for (int i = 1; i <= 4; i++) begin
            tx(user_io_pkg::CMD_QUERY_OUT_ONE, 4'(i), 4'h0);
            check("out_one", 16'(i != 2), r.value);
        end
        tx(user_io_pkg::CMD_OUT_OFF, 4'h1, 4'h0);
        check("pending", 16'hd, 16'(uo));
        tx(user_io_pkg::CMD_OUT_OFF, 4'h3, 4'h4);
        check("run", 16'h8, 16'(uo));
        $display("outputs done");
    endtask
    task automatic t_latch;
        in_n = 3'h6;
        repeat (5) @(negedge clk);
        check("flag_set", 16'h1, 16'(flag));
        tx(user_io_pkg::CMD_QUERY_LIVE, 4'h1, 4'h0);
        check("live", 16'h1, r.value);
        for (int k = 0; k < 2; k++) begin
            tx(user_io_pkg::CMD_QUERY_IN_BYTE, 4'h0, 4'h0);
            check("in_byte", 16'h1, r.value);
        end
        for (int k = 0; k < 2; k++) begin
            tx(user_io_pkg::CMD_QUERY_LATCH, 4'h1, 4'h0);
            check("latch", 16'(k == 0), r.value);
            check("flag_clr", 16'h0, 16'(flag));
        end
        in_n = 3'h7;
        tx(user_io_pkg::CMD_SET_HOME_FLAG, 4'h0, 4'hc);
        check("home_off", 16'h0, 16'(he));
        in_n = 3'h3;
        home_n = 1'b0;
        repeat (5) @(negedge clk);
        in_n = 3'h7;
        home_n = 1'b1;
        tx(user_io_pkg::CMD_QUERY_IN_BYTE, 4'h0, 4'h0);
        check("in_byte7", 16'h44, r.value);
        tx(user_io_pkg::CMD_TEST_INPUT, 4'h7, 4'h1);
        check("jump_in", 16'h3, 16'({j.valid, j.take}));
        tx(user_io_pkg::CMD_TEST_INPUT, 4'h1, 4'h1);
        check("stay_in", 16'h2, 16'({j.valid, j.take}));
        tx(user_io_pkg::CMD_CLEAR_LATCH_FLAG, 4'h0, 4'h4);
        check("clr_all", 16'h0, 16'(flag));
        tx(user_io_pkg::CMD_SET_HOME_FLAG, 4'h0, 4'h4);
        check("home_on", 16'h1, 16'(he));
        $display("latch done");
    endtask
    task automatic t_analog;
        logic [1:0] exp [5] = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h0};
        for (int k = 1; k <= 2; k++) begin
            tx(user_io_pkg::CMD_QUERY_ANALOG, 4'(k), 4'h0);
            check("analog", k == 1 ? 16'h7c : 16'h19, r.value);
        end
        // 0x7c counts is exactly 2480 mV, so the thresholds straddle it
        for (int k = 0; k < 5; k++) begin
            host.send(k < 2 ? user_io_pkg::CMD_TEST_BELOW : user_io_pkg::CMD_TEST_ABOVE, 4'h0,
                      13'(2480 + (k == 1) - (k == 2) + 2521 * (k == 4)), 4'h1, r, j);
            check("analog_jump", 16'(exp[k]), 16'({j.valid, j.take}));
        end
        $display("analog done");
    endtask
    task automatic t_modes;
        tx(user_io_pkg::CMD_QUERY_OUT_BYTE, 4'h0, 4'h1);
        check("refused", 16'h3, 16'({r.valid, r.refused}));
        tx(user_io_pkg::CMD_SET_TAMPER_FLAG, 4'h0, 4'hc);
        check("tamper_on", 16'h1, 16'({te, tse}));
        tx(user_io_pkg::CMD_SET_TAMPER_FLAG, 4'h0, 4'h4);
        check("tamper_off", 16'h2, 16'({te, tse}));
        tx(user_io_pkg::CMD_SET_HOME_FLAG, 4'h0, 4'hc);
        do_reset();
        check("unsaved", 16'h1, 16'(he));
        tx(user_io_pkg::CMD_SET_HOME_FLAG, 4'h0, 4'hc);
        tx(user_io_pkg::CMD_SAVE, 4'h0, 4'h4);
        do_reset();
        check("saved", 16'h0, 16'(he));
        $display("modes done");
    endtask
    initial begin
        do_reset();
        check("reset_out", 16'h0, 16'({uo, flag}));
        t_outputs();
        t_latch();
        t_analog();
        t_modes();
        conclude();
    end
endmodule // user_io_latch_and_query_test
